// [design/urxs_consts.svh]
// Constants of the serial receive status and register block.
// Included by the package and the top module; definitions only.
`ifndef URXS_CONSTS_SVH
`define URXS_CONSTS_SVH

// Register indices; byte address is four times the index
`define URXS_IDX_MODE      12'h0220
`define URXS_IDX_STATUS    12'h0222
`define URXS_IDX_TXDATA    12'h0224
`define URXS_IDX_RXDATA    12'h0226
`define URXS_IDX_BAUD      12'h0228

// Reset values
`define URXS_RST_MODE      16'h0000
`define URXS_RST_STATUS    16'h0110
`define URXS_RST_TXDATA    16'h0000
`define URXS_RST_RXDATA    16'h0000
`define URXS_RST_BAUD      16'h0000

// Status field positions
`define URXS_ST_AVAIL      0
`define URXS_ST_OVFL       1
`define URXS_ST_STOP_BIT_FAULT_FLAG       2
`define URXS_ST_PARITY_FAULT_FLAG       3
`define URXS_ST_IDLE       4
`define URXS_ST_TXEMPTY    8
// Status bits that software simply stores
`define URXS_ST_RW_MASK    16'hECE0

// Mode field positions
`define URXS_MD_EN         15
`define URXS_MD_FAST       3
`define URXS_MD_PDSEL_HI   2
`define URXS_MD_PDSEL_LO   1
`define URXS_MD_STOP2      0

// Timing: log2 of clocks per bit per divisor step, normal and fast rate
`define URXS_OVS_NORM      4
`define URXS_OVS_FAST      2

// Receive storage
`define URXS_QUEUE_DEPTH   3'd4
`define URXS_DATA_BITS     9

`endif

// [design/urxs_pkg.sv]
// Types of the serial receive status and register block.
// Assumes urxs_consts.svh is on the include path.
`include "urxs_consts.svh"

package urxs_pkg;

  typedef struct packed {
    logic [`URXS_DATA_BITS-1:0] data;
    logic                       parity_fault_flag;
    logic                       stop_bit_fault_flag;
  } urxs_char_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP1,
    RX_STOP2
  } urxs_rx_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } urxs_apb_req_t;

endpackage

// [design/urxs_top.sv]
// Receive side of an asynchronous serial port with its APB register map.
// Assumes a 20 MHz ref_clk_i and a serial line synchronous to it.
`timescale 1ns/1ps
`include "urxs_consts.svh"

////////////////////////////////////////////////////////////////////////////
// Two-entry buffer with valid and ready on both sides
module urxs_buf2 #(
  parameter int W = 11
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o,
  output logic [1:0]        count_o
);

  logic [W-1:0] mem_r [2];
  logic         wr_ptr_r;
  logic         rd_ptr_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_r != 2'd2);
  assign out_valid_o = (cnt_r != 2'd0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign count_o     = cnt_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end
    else if (push && !flush_i)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'd0;
    end
    else if (flush_i)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
      begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      case ({push, pop})
        2'b10:   cnt_r <= cnt_r + 2'd1;
        2'b01:   cnt_r <= cnt_r - 2'd1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// Top: APB slave, receiver, four-character queue
module urxs_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_i
);

  urxs_pkg::urxs_apb_req_t  req;
  urxs_pkg::urxs_rx_state_t state_r;
  urxs_pkg::urxs_char_t     rx_char;
  urxs_pkg::urxs_char_t     mid_char;
  urxs_pkg::urxs_char_t     head_char;

  logic [15:0] mode_r;
  logic [15:0] status_rw_r;
  logic [15:0] baud_r;
  logic        ovfl_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  logic [20:0] bit_len;
  logic [20:0] tick_r;
  logic [3:0]  bit_idx_r;
  logic [8:0]  shift_r;
  logic        par_bad_r;
  logic        stop_bad_r;
  logic        char_done;
  logic [3:0]  data_len;
  logic        par_on;

  logic        hit_mode;
  logic        hit_status;
  logic        hit_tx;
  logic        hit_rx;
  logic        hit_baud;
  logic        hit_any;
  logic        wr_acc;
  logic        rd_acc;
  logic        flush;
  logic        q_in_ready;
  logic        mid_valid;
  logic        mid_ready;
  logic        head_valid;
  logic        pop_head;
  logic [1:0]  cnt_a;
  logic [1:0]  cnt_b;
  logic [2:0]  q_count;
  logic        q_full;
  logic [15:0] status_view;

  //////////////////////////////////////////////////////////////////////////
  // APB decode
  assign req.psel    = psel_i;
  assign req.penable = penable_i;
  assign req.pwrite  = pwrite_i;
  assign req.paddr   = paddr_i;
  assign req.pwdata  = pwdata_i;

  // Some printed offsets are not word aligned, so each is a word index
  assign hit_mode   = (req.paddr == {18'h0_0000, `URXS_IDX_MODE, 2'b00});
  assign hit_status = (req.paddr == {18'h0_0000, `URXS_IDX_STATUS, 2'b00});
  assign hit_tx     = (req.paddr == {18'h0_0000, `URXS_IDX_TXDATA, 2'b00});
  assign hit_rx     = (req.paddr == {18'h0_0000, `URXS_IDX_RXDATA, 2'b00});
  assign hit_baud   = (req.paddr == {18'h0_0000, `URXS_IDX_BAUD, 2'b00});
  assign hit_any    = hit_mode | hit_status | hit_tx | hit_rx | hit_baud;

  // No wait state: read data is captured in setup, answered in the first access cycle
  assign pready_o  = req.psel & req.penable;
  assign prdata_o  = prdata_r;
  assign pslverr_o = pslverr_r;
  assign wr_acc    = pready_o & req.pwrite & hit_any;
  assign rd_acc    = pready_o & ~req.pwrite & hit_any;

  //////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_r      <= `URXS_RST_MODE;
      baud_r      <= `URXS_RST_BAUD;
      status_rw_r <= `URXS_RST_STATUS & `URXS_ST_RW_MASK;
    end
    else if (wr_acc)
    begin
      if (hit_mode)
      begin
        mode_r <= req.pwdata[15:0];
      end
      if (hit_baud)
      begin
        baud_r <= req.pwdata[15:0];
      end
      if (hit_status)
      begin
        status_rw_r <= req.pwdata[15:0] & `URXS_ST_RW_MASK;
      end
    end
  end

  // Overflow: set wins over a same-cycle clear
  assign flush = wr_acc & hit_status & ovfl_r
               & ~req.pwdata[`URXS_ST_OVFL];

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ovfl_r <= 1'b0;
    end
    else if (char_done && q_full)
    begin
      ovfl_r <= 1'b1;
    end
    else if (flush)
    begin
      ovfl_r <= 1'b0;
    end
  end

  always_comb
  begin
    status_view                 = status_rw_r;
    status_view[`URXS_ST_TXEMPTY] = 1'b1;
    status_view[`URXS_ST_IDLE]  = (state_r == urxs_pkg::RX_IDLE);
    status_view[`URXS_ST_PARITY_FAULT_FLAG]  = head_valid & head_char.parity_fault_flag;
    status_view[`URXS_ST_STOP_BIT_FAULT_FLAG]  = head_valid & head_char.stop_bit_fault_flag;
    status_view[`URXS_ST_OVFL]  = ovfl_r;
    status_view[`URXS_ST_AVAIL] = head_valid;
  end

  // Read data captured at setup; upper bits stay zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (req.psel && !req.penable)
    begin
      pslverr_r <= ~hit_any;
      prdata_r  <= 32'h0000_0000;
      if (!req.pwrite)
      begin
        if (hit_mode)
        begin
          prdata_r[15:0] <= mode_r;
        end
        if (hit_status)
        begin
          prdata_r[15:0] <= status_view;
        end
        if (hit_rx && head_valid)
        begin
          prdata_r[8:0] <= head_char.data;
        end
        if (hit_baud)
        begin
          prdata_r[15:0] <= baud_r;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver bit timing
  always_comb
  begin
    if (mode_r[`URXS_MD_FAST])
    begin
      bit_len = {4'h0, {1'b0, baud_r} + 17'h0_0001} << `URXS_OVS_FAST;
    end
    else
    begin
      bit_len = {4'h0, {1'b0, baud_r} + 17'h0_0001} << `URXS_OVS_NORM;
    end
  end

  assign par_on   = mode_r[`URXS_MD_PDSEL_HI] ^ mode_r[`URXS_MD_PDSEL_LO];
  assign data_len = (mode_r[`URXS_MD_PDSEL_HI] & mode_r[`URXS_MD_PDSEL_LO])
                  ? 4'd9 : 4'd8;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r    <= urxs_pkg::RX_IDLE;
      tick_r     <= 21'h0_0000;
      bit_idx_r  <= 4'd0;
      shift_r    <= 9'h000;
      par_bad_r  <= 1'b0;
      stop_bad_r <= 1'b0;
    end
    else if (flush || !mode_r[`URXS_MD_EN])
    begin
      state_r <= urxs_pkg::RX_IDLE;
      tick_r  <= 21'h0_0000;
      shift_r <= 9'h000;
    end
    else if (state_r != urxs_pkg::RX_IDLE && tick_r != 21'h0_0000)
    begin
      tick_r <= tick_r - 21'h0_0001;
    end
    else
    begin
      case (state_r)
        urxs_pkg::RX_IDLE:
        begin
          if (!rx_i)
          begin
            state_r    <= urxs_pkg::RX_START;
            tick_r     <= bit_len >> 1;
            bit_idx_r  <= 4'd0;
            shift_r    <= 9'h000;
            par_bad_r  <= 1'b0;
            stop_bad_r <= 1'b0;
          end
        end
        urxs_pkg::RX_START:
        begin
          // A glitch shorter than half a bit is not a start
          state_r <= rx_i ? urxs_pkg::RX_IDLE : urxs_pkg::RX_DATA;
          tick_r  <= bit_len - 21'h0_0001;
        end
        urxs_pkg::RX_DATA:
        begin
          shift_r[bit_idx_r] <= rx_i;
          bit_idx_r          <= bit_idx_r + 4'd1;
          tick_r             <= bit_len - 21'h0_0001;
          if (bit_idx_r == data_len - 4'd1)
          begin
            state_r <= par_on ? urxs_pkg::RX_PARITY : urxs_pkg::RX_STOP1;
          end
        end
        urxs_pkg::RX_PARITY:
        begin
          // Odd parity when the high select bit is set
          par_bad_r <= (^shift_r[7:0]) ^ rx_i
                     ^ mode_r[`URXS_MD_PDSEL_HI];
          tick_r    <= bit_len - 21'h0_0001;
          state_r   <= urxs_pkg::RX_STOP1;
        end
        urxs_pkg::RX_STOP1:
        begin
          stop_bad_r <= ~rx_i;
          tick_r     <= bit_len - 21'h0_0001;
          state_r    <= mode_r[`URXS_MD_STOP2] ? urxs_pkg::RX_STOP2
                                               : urxs_pkg::RX_IDLE;
        end
        urxs_pkg::RX_STOP2:
        begin
          stop_bad_r <= stop_bad_r | ~rx_i;
          state_r    <= urxs_pkg::RX_IDLE;
        end
        default:
        begin
          state_r <= urxs_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Character complete in the cycle the last stop bit is sampled
  assign char_done = mode_r[`URXS_MD_EN] & (tick_r == 21'h0_0000)
                   & ((state_r == urxs_pkg::RX_STOP1
                       && !mode_r[`URXS_MD_STOP2])
                      || state_r == urxs_pkg::RX_STOP2);

  // Stop fault uses this cycle's sample as well
  always_comb
  begin
    rx_char.data = shift_r;
    rx_char.parity_fault_flag = par_bad_r;
    if (state_r == urxs_pkg::RX_STOP2)
    begin
      rx_char.stop_bit_fault_flag = stop_bad_r | ~rx_i;
    end
    else
    begin
      rx_char.stop_bit_fault_flag = ~rx_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Four-character queue: intake pair feeding an output pair
  assign q_count  = {1'b0, cnt_a} + {1'b0, cnt_b};
  assign q_full   = (q_count == `URXS_QUEUE_DEPTH) | ~q_in_ready;
  assign pop_head = rd_acc & hit_rx & head_valid;

  urxs_buf2 #(
    .W ($bits(urxs_pkg::urxs_char_t))
  ) u_intake (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (flush),
    .in_valid_i  (char_done & ~q_full),
    .in_data_i   (rx_char),
    .in_ready_o  (q_in_ready),
    .out_valid_o (mid_valid),
    .out_ready_i (mid_ready),
    .out_data_o  (mid_char),
    .count_o     (cnt_a)
  );

  // Only reads and a flush drain the output pair; when it is full it back-pressures the intake
  urxs_buf2 #(
    .W ($bits(urxs_pkg::urxs_char_t))
  ) u_output (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (flush),
    .in_valid_i  (mid_valid),
    .in_data_i   (mid_char),
    .in_ready_o  (mid_ready),
    .out_valid_o (head_valid),
    .out_ready_i (pop_head),
    .out_data_o  (head_char),
    .count_o     (cnt_b)
  );

endmodule

// [verif/urxs_chk.sv]
// Checker of the serial receive block, seen from the top ports only.
// Bound to urxs_top from the testbench top file.
`timescale 1ns/1ps
`include "urxs_consts.svh"
module urxs_chk (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        rx_i
);
  localparam logic [31:0] A_MD = {18'h0, `URXS_IDX_MODE, 2'b00};
  localparam logic [31:0] A_ST = {18'h0, `URXS_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_TX = {18'h0, `URXS_IDX_TXDATA, 2'b00};
  localparam logic [31:0] A_RX = {18'h0, `URXS_IDX_RXDATA, 2'b00};
  localparam logic [31:0] A_BD = {18'h0, `URXS_IDX_BAUD, 2'b00};
  logic acc;
  logic rd_st;
  logic wr_st;
  logic mapped;
  logic sticky_r;
  assign acc    = psel_i & penable_i;
  assign rd_st  = acc & !pwrite_i & (paddr_i == A_ST);
  assign wr_st  = acc & pwrite_i & (paddr_i == A_ST);
  assign mapped = paddr_i inside {A_MD, A_ST, A_TX, A_RX, A_BD};
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  // Last status read saw overflow; any status write ends that claim
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      sticky_r <= 1'b0;
    else if (rd_st)
      sticky_r <= prdata_o[1];
    else if (wr_st)
      sticky_r <= 1'b0;
  ////////////////////////////////////////////////////////////////////////
  a_ready_access: assert property (pready_o == acc)
    else $error("pready does not follow the access phase");
  a_upper_zero: assert property
    (acc && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_rx_upper: assert property
    (acc && !pwrite_i && paddr_i == A_RX |-> prdata_o[15:9] == 7'h00)
    else $error("receive data bits above 8 not zero");
  a_txempty_one: assert property (rd_st |-> prdata_o[8])
    else $error("status bit 8 not set");
  a_flags_need_data: assert property
    (rd_st |-> prdata_o[0] || prdata_o[3:2] == 2'b00)
    else $error("fault flags set with empty queue");
  a_unmapped_err: assert property
    (acc && !mapped |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr_o)
    else $error("mapped access refused");
  a_ovfl_sticky: assert property (rd_st && sticky_r |-> prdata_o[1])
    else $error("overflow flag dropped without clear");
  a_ovfl_flush: assert property
    (wr_st && !pwdata_i[1] && sticky_r ##[1:3] rd_st
      |-> prdata_o[1:0] == 2'b00)
    else $error("overflow clear did not empty the queue");
  cover property (rd_st && prdata_o[1]);
  cover property (rd_st && prdata_o[3]);
  cover property (rd_st && prdata_o[2]);
  cover property (acc && !mapped);
endmodule

// [verif/urxs_top_test.sv]
// Testbench of the serial receive block: APB master and remote sender.
// Assumes urxs_consts.svh on the include path.
`timescale 1ns/1ps
`include "urxs_consts.svh"
module urxs_top_test;
  localparam logic [31:0] A_MD = {18'h0, `URXS_IDX_MODE, 2'b00};
  localparam logic [31:0] A_ST = {18'h0, `URXS_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_TX = {18'h0, `URXS_IDX_TXDATA, 2'b00};
  localparam logic [31:0] A_RX = {18'h0, `URXS_IDX_RXDATA, 2'b00};
  localparam logic [31:0] A_BD = {18'h0, `URXS_IDX_BAUD, 2'b00};
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        rx;
  logic        err_q;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd_q;
  int          mismatches;
  int          num_checks;
  int          cycles;
  urxs_top i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_i(rx));
  urxs_uart_tx #(.BIT_CYC(16)) i_tx (.ref_clk_i(ref_clk_i), .rx_o(rx));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // No local limit: only the bench timeout ends a stuck wait
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd_q, exp);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(A_MD, 32'h0000_0000);
    rd(A_ST, 32'h0000_0110);
    rd(A_RX, 32'h0000_0000);
    rd(A_BD, 32'h0000_0000);
    rd(32'h0000_0884, 32'h0000_0000);
    check({31'h0, err_q}, 32'h0000_0001);
    wr(A_BD, 32'hFFFF_1234);
    rd(A_BD, 32'h0000_1234);
    wr(A_BD, 32'h0000_0000);
    wr(A_TX, 32'h0000_01AB);
    rd(A_TX, 32'h0000_0000);
    wr(A_MD, 32'h0000_8000);
    rd(A_MD, 32'h0000_8000);
    fork
      i_tx.send(8'h5A, 2'd0, 1'b0, 1'b0);
      begin
        repeat (40) @(posedge ref_clk_i);
        rd(A_ST, 32'h0000_0100);
      end
    join
    rd(A_ST, 32'h0000_0111);
    wr(A_ST, 32'h0000_001D);
    rd(A_ST, 32'h0000_0111);
    rd(A_RX, 32'h0000_005A);
    rd(A_ST, 32'h0000_0110);
    // Even parity: parity fault, stop fault, then a clean character
    wr(A_MD, 32'h0000_8002);
    i_tx.send(8'h31, 2'd1, 1'b1, 1'b0);
    i_tx.send(8'h32, 2'd1, 1'b0, 1'b1);
    i_tx.send(8'h33, 2'd1, 1'b0, 1'b0);
    rd(A_ST, 32'h0000_0119);
    rd(A_RX, 32'h0000_0031);
    rd(A_ST, 32'h0000_0115);
    rd(A_RX, 32'h0000_0032);
    rd(A_ST, 32'h0000_0111);
    rd(A_RX, 32'h0000_0033);
    wr(A_MD, 32'h0000_8004);
    i_tx.send(8'h34, 2'd2, 1'b0, 1'b0);
    rd(A_ST, 32'h0000_0111);
    rd(A_RX, 32'h0000_0034);
    // Fill to four, then one more overruns
    wr(A_MD, 32'h0000_8000);
    for (int i = 0; i < 4; i++)
      i_tx.send(8'h40 + 8'(i), 2'd0, 1'b0, 1'b0);
    rd(A_ST, 32'h0000_0111);
    i_tx.send(8'h44, 2'd0, 1'b0, 1'b0);
    rd(A_ST, 32'h0000_0113);
    rd(A_RX, 32'h0000_0040);
    rd(A_ST, 32'h0000_0113);
    wr(A_ST, 32'h0000_0000);
    rd(A_ST, 32'h0000_0110);
    rd(A_RX, 32'h0000_0000);
    // Fast rate, nine data bits, two stop bits; same 16-clock bit time
    wr(A_BD, 32'h0000_0003);
    wr(A_MD, 32'h0000_800F);
    i_tx.send(8'h01, 2'd1, 1'b0, 1'b0);
    rd(A_ST, 32'h0000_0111);
    rd(A_RX, 32'h0000_0101);
    print_verdict();
  end
endmodule
bind urxs_top urxs_chk i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i));

// [verif/urxs_uart_tx.sv]
// Remote serial transmitter driving the block's receive line.
// Assumes bit time of BIT_CYC reference clocks; line idles high.
`timescale 1ns/1ps
module urxs_uart_tx #(
  parameter int BIT_CYC = 16
) (
  input  wire logic ref_clk_i,
  output logic      rx_o
);
  initial rx_o = 1'b1;
  task automatic put(input logic b);
    @(posedge ref_clk_i);
    rx_o <= b;
    repeat (BIT_CYC - 1) @(posedge ref_clk_i);
  endtask
  // par: 0 none, 1 even, 2 odd
  task automatic send(input logic [7:0] d, input logic [1:0] par,
                      input logic bad_par, input logic bad_stop);
    put(1'b0);
    for (int i = 0; i < 8; i++)
      put(d[i]);
    if (par != 2'd0)
      put(^d ^ par[1] ^ bad_par);
    // Short low stop: seen as fault, too brief to pass as a start
    if (bad_stop)
    begin
      @(posedge ref_clk_i);
      rx_o <= 1'b0;
      repeat (BIT_CYC / 2 + 3) @(posedge ref_clk_i);
    end
    put(1'b1);
    put(1'b1);
  endtask
endmodule
